// *** core/cec_pkg.sv ***
package cec_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NCMP = 4;
  localparam int unsigned AW = 8;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADDR_STAT = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL_STEP = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ==========================================================
  // Field positions
  localparam int STAT_HALT_BIT = 15;
  localparam int STAT_EVT_LSB = 8;
  localparam int STAT_RES_LSB = 0;
  localparam int CTRL_OE_BIT = 14;

  // ==========================================================
  // Reset values and write masks
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hE2D3;
  localparam logic STAT_HALT_RST = 1'b0;
  localparam logic [NCMP-1:0] IRQ_MASK_RST = 4'h0;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY = 2'h3
  } cec_edge_t;

  typedef struct packed {
    logic comparator_on;
    logic pin_drive_enable;
    logic result_invert;
    logic [2:0] rsvd_hi;
    logic sticky_event_flag;
    logic result_bit;
    cec_edge_t edge_select;
    logic rsvd_mid;
    logic reference_select;
    logic [1:0] rsvd_lo;
    logic [1:0] input_channel_select;
  } cec_ctrl_t;

  typedef struct packed {
    logic powered;
    logic reference_select;
    logic [1:0] input_channel_select;
  } cec_analog_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } cec_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cec_axi_rsp_t;

endpackage

// *** core/cec_chan.sv ***
`timescale 1ns/10ps
module cec_chan (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic raw_i,
  input wire logic run_i,
  input wire cec_pkg::cec_ctrl_t ctrl_i,
  output logic result_o,
  output logic trig_o
);

  typedef struct packed {
    logic on_d;
    logic result;
    logic trig;
  } cec_chan_st_t;

  cec_chan_st_t st_reg, st_next;
  logic corrected;
  logic armed;

  // ==========================================================
  // Edge logic
  assign corrected = raw_i ^ ctrl_i.result_invert;
  // A pending pulse also blocks, since the flag only lands one edge later
  assign armed = st_reg.on_d && !st_reg.trig && !ctrl_i.sticky_event_flag;

  always_comb begin
    st_next = st_reg;
    st_next.trig = 1'b0;
    if (!ctrl_i.comparator_on) begin
      st_next = '0;
    end else if (run_i) begin
      st_next.on_d = 1'b1;
      st_next.result = corrected;
      case (ctrl_i.edge_select)
        cec_pkg::EDGE_ANY: st_next.trig = armed && (corrected != st_reg.result);
        cec_pkg::EDGE_FALL: st_next.trig = armed && st_reg.result && !corrected;
        cec_pkg::EDGE_RISE: st_next.trig = armed && !st_reg.result && corrected;
        default: st_next.trig = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result_o = st_reg.result;
  assign trig_o = st_reg.trig;

  // ==========================================================
  // Checks
  default clocking cec_chan_cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  polarity_path_a: assert property ((ctrl_i.comparator_on && run_i)
    |=> result_o == $past(corrected))
    else $error("result bit does not follow corrected input");
  off_quiet_a: assert property (!ctrl_i.comparator_on |=> (!result_o && !trig_o))
    else $error("disabled comparator not inactive");
  edge_off_a: assert property ((ctrl_i.edge_select == cec_pkg::EDGE_OFF) |=> !trig_o)
    else $error("pulse while edge select is off");
  any_edge_a: assert property ((ctrl_i.edge_select == cec_pkg::EDGE_ANY && armed
    && ctrl_i.comparator_on && run_i && corrected != st_reg.result) |=> trig_o)
    else $error("change missed in any-edge mode");
  rise_only_a: assert property ((trig_o && $past(ctrl_i.edge_select) == cec_pkg::EDGE_RISE)
    |-> (result_o && !$past(result_o)))
    else $error("rise pulse without rising result");
  fall_only_a: assert property ((trig_o && $past(ctrl_i.edge_select) == cec_pkg::EDGE_FALL)
    |-> (!result_o && $past(result_o)))
    else $error("fall pulse without falling result");

endmodule // cec_chan

// *** core/cec_irq.sv ***
`timescale 1ns/10ps
module cec_irq (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [cec_pkg::NCMP-1:0] event_i,
  input wire logic [cec_pkg::NCMP-1:0] clear_i,
  input wire logic mask_we_i,
  input wire logic [cec_pkg::NCMP-1:0] mask_i,
  output logic [cec_pkg::NCMP-1:0] status_o,
  output logic [cec_pkg::NCMP-1:0] mask_o,
  output logic irq_o
);

  typedef struct packed {
    logic [cec_pkg::NCMP-1:0] status;
    logic [cec_pkg::NCMP-1:0] mask;
  } cec_irq_st_t;

  cec_irq_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    // Set beats a simultaneous clear so no event is lost
    st_next.status = (st_reg.status & ~clear_i) | event_i;
    if (mask_we_i) begin
      st_next.mask = mask_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.mask <= cec_pkg::IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_o = st_reg.status;
  assign mask_o = st_reg.mask;
  assign irq_o = |(st_reg.status & st_reg.mask);

endmodule // cec_irq

// *** core/cec_top.sv ***
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module cec_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire cec_pkg::cec_axi_req_t axi_req_i,
  output cec_pkg::cec_axi_rsp_t axi_rsp_o,
  input wire logic idle_i,
  input wire logic [cec_pkg::NCMP-1:0] raw_result_i,
  output cec_pkg::cec_analog_cfg_t [cec_pkg::NCMP-1:0] analog_cfg_o,
  output logic [cec_pkg::NCMP-1:0] pin_o,
  output logic [cec_pkg::NCMP-1:0] pin_oe_o,
  output logic [cec_pkg::NCMP-1:0] event_pulse_o,
  output logic irq_o
);

  localparam int unsigned N = cec_pkg::NCMP;

  // ==========================================================
  // State
  typedef struct packed {
    logic halt;
    cec_pkg::cec_ctrl_t [N-1:0] ctrl;
    logic aw_have;
    logic [cec_pkg::AW-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cec_top_st_t;

  cec_top_st_t st_reg, st_next;

  logic run;
  logic wr_go;
  logic rd_go;
  logic wr_ok;
  logic rd_ok;
  logic wr_stat;
  logic mask_we;
  logic [N-1:0] wr_ctrl;
  logic [N-1:0] irq_clr;
  logic [N-1:0] irq_stat;
  logic [N-1:0] irq_mask;
  logic [N-1:0] res_vec;
  logic [N-1:0] evt_vec;
  logic [N-1:0] trig_vec;
  logic [15:0] lane_mask;
  logic [15:0] wr_mask;
  logic [15:0] stat_word;
  logic [31:0] rd_word;

  // ==========================================================
  // Idle halt
  // Halting freezes results in place rather than clearing them, so
  // software sees the last value taken before the idle period.
  assign run = !(st_reg.halt && idle_i);

  // ==========================================================
  // Comparator channels
  for (genvar k = 0; k < N; k++) begin : g_cmp
    cec_chan u_chan (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .raw_i(raw_result_i[k]),
      .run_i(run),
      .ctrl_i(st_reg.ctrl[k]),
      .result_o(res_vec[k]),
      .trig_o(trig_vec[k])
    );

    assign evt_vec[k] = st_reg.ctrl[k].sticky_event_flag;
    assign pin_oe_o[k] = st_reg.ctrl[k].pin_drive_enable && st_reg.ctrl[k].comparator_on;
    assign pin_o[k] = pin_oe_o[k] && res_vec[k];
    assign analog_cfg_o[k].powered = st_reg.ctrl[k].comparator_on && run;
    assign analog_cfg_o[k].reference_select = st_reg.ctrl[k].reference_select;
    assign analog_cfg_o[k].input_channel_select = st_reg.ctrl[k].input_channel_select;

    evt_mirror_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (rd_go && axi_req_i.araddr == cec_pkg::ADDR_STAT)
      |=> axi_rsp_o.rdata[cec_pkg::STAT_EVT_LSB + k] == $past(evt_vec[k]))
      else $error("event mirror differs from sticky flag");
    res_mirror_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (rd_go && axi_req_i.araddr == cec_pkg::ADDR_STAT)
      |=> axi_rsp_o.rdata[cec_pkg::STAT_RES_LSB + k] == $past(res_vec[k]))
      else $error("result mirror differs from result bit");
    flag_blocks_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $past(evt_vec[k]) |-> !trig_vec[k])
      else $error("pulse while sticky flag set");
    flag_sets_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      trig_vec[k] |=> (evt_vec[k] && irq_stat[k]))
      else $error("pulse did not set sticky flag");
    pin_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_ctrl[k] && st_reg.wstrb[1] && !st_reg.wdata[cec_pkg::CTRL_OE_BIT])
      |=> (!pin_oe_o[k] && !pin_o[k]))
      else $error("pin driven after output enable cleared");
  end

  assign event_pulse_o = trig_vec;

  // ==========================================================
  // Interrupt status and mask
  cec_irq u_irq (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .event_i(trig_vec),
    .clear_i(irq_clr),
    .mask_we_i(mask_we),
    .mask_i(st_reg.wdata[N-1:0]),
    .status_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ==========================================================
  // Bus handshake
  // One write and one read in flight; address and data may come in
  // either order and are held until both are present.
  assign axi_rsp_o.awready = !st_reg.aw_have && !st_reg.bvalid;
  assign axi_rsp_o.wready = !st_reg.w_have && !st_reg.bvalid;
  assign axi_rsp_o.bvalid = st_reg.bvalid;
  assign axi_rsp_o.bresp = st_reg.bresp;
  assign axi_rsp_o.arready = !st_reg.rvalid;
  assign axi_rsp_o.rvalid = st_reg.rvalid;
  assign axi_rsp_o.rdata = st_reg.rdata;
  assign axi_rsp_o.rresp = st_reg.rresp;

  assign wr_go = st_reg.aw_have && st_reg.w_have;
  assign rd_go = axi_req_i.arvalid && !st_reg.rvalid;
  assign lane_mask = {{8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
  assign wr_mask = cec_pkg::CTRL_WMASK & lane_mask;

  // ==========================================================
  // Shared status word
  always_comb begin
    stat_word = 16'h0000;
    stat_word[cec_pkg::STAT_HALT_BIT] = st_reg.halt;
    stat_word[cec_pkg::STAT_EVT_LSB +: N] = evt_vec;
    stat_word[cec_pkg::STAT_RES_LSB +: N] = res_vec;
  end

  // ==========================================================
  // Read decode
  always_comb begin
    cec_pkg::cec_ctrl_t view;
    view = '0;
    rd_word = 32'h0000_0000;
    rd_ok = 1'b0;
    if (axi_req_i.araddr == cec_pkg::ADDR_STAT) begin
      rd_word[15:0] = stat_word;
      rd_ok = 1'b1;
    end
    if (axi_req_i.araddr == cec_pkg::ADDR_IRQ_STAT) begin
      rd_word[N-1:0] = irq_stat;
      rd_ok = 1'b1;
    end
    if (axi_req_i.araddr == cec_pkg::ADDR_IRQ_MASK) begin
      rd_word[N-1:0] = irq_mask;
      rd_ok = 1'b1;
    end
    for (int i = 0; i < N; i++) begin
      if (axi_req_i.araddr == cec_pkg::ADDR_CTRL1 + 8'(i) * cec_pkg::ADDR_CTRL_STEP) begin
        view = st_reg.ctrl[i];
        view.result_bit = res_vec[i];
        rd_word[15:0] = view;
        rd_ok = 1'b1;
      end
    end
  end

  // ==========================================================
  // Write decode
  always_comb begin
    wr_ok = 1'b0;
    wr_stat = 1'b0;
    mask_we = 1'b0;
    wr_ctrl = '0;
    irq_clr = '0;
    if (st_reg.awaddr == cec_pkg::ADDR_STAT) begin
      wr_ok = 1'b1;
      wr_stat = wr_go;
    end
    if (st_reg.awaddr == cec_pkg::ADDR_IRQ_STAT) begin
      wr_ok = 1'b1;
      if (wr_go && st_reg.wstrb[0]) begin
        irq_clr = st_reg.wdata[N-1:0];
      end
    end
    if (st_reg.awaddr == cec_pkg::ADDR_IRQ_MASK) begin
      wr_ok = 1'b1;
      mask_we = wr_go && st_reg.wstrb[0];
    end
    for (int i = 0; i < N; i++) begin
      if (st_reg.awaddr == cec_pkg::ADDR_CTRL1 + 8'(i) * cec_pkg::ADDR_CTRL_STEP) begin
        wr_ok = 1'b1;
        wr_ctrl[i] = wr_go;
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    if (axi_req_i.awvalid && axi_rsp_o.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && axi_rsp_o.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = axi_req_i.wdata;
      st_next.wstrb = axi_req_i.wstrb;
    end
    if (wr_go) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_ok ? cec_pkg::RESP_OKAY : cec_pkg::RESP_SLVERR;
    end
    if (st_reg.bvalid && axi_req_i.bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && axi_req_i.rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_word;
      st_next.rresp = rd_ok ? cec_pkg::RESP_OKAY : cec_pkg::RESP_SLVERR;
    end
    if (wr_stat && st_reg.wstrb[1]) begin
      st_next.halt = st_reg.wdata[cec_pkg::STAT_HALT_BIT];
    end
    for (int i = 0; i < N; i++) begin
      if (wr_ctrl[i]) begin
        // Result bit is outside the write mask: it is always live
        st_next.ctrl[i] = cec_pkg::cec_ctrl_t'((st_reg.ctrl[i] & ~wr_mask)
          | (st_reg.wdata[15:0] & wr_mask));
      end
      // Hardware set wins over a software clear in the same cycle
      if (trig_vec[i]) begin
        st_next.ctrl[i].sticky_event_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.ctrl <= {N{cec_pkg::CTRL_RST}};
      st_reg.halt <= cec_pkg::STAT_HALT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Checks
  default clocking cec_top_cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  halt_freeze_a: assert property ((st_reg.halt && idle_i)
    |=> ($stable(res_vec) && trig_vec == '0))
    else $error("comparators moved while halted in idle");
  idle_runs_a: assert property ((!st_reg.halt && idle_i && st_reg.ctrl[0].comparator_on)
    |-> analog_cfg_o[0].powered)
    else $error("comparator stopped in idle without halt");
  write_answer_a: assert property (wr_go |=> (axi_rsp_o.bvalid && !st_reg.aw_have))
    else $error("write answer not given one cycle after both halves");
  read_answer_a: assert property (rd_go |=> axi_rsp_o.rvalid)
    else $error("read answer not given one cycle after address");

endmodule // cec_top

// *** testbench/cec_partner.sv ***
`timescale 1ns/10ps
// ==========================================
// Analog comparator cores seen from the digital side
module cec_partner (
  input wire logic clk_i,
  input wire cec_pkg::cec_analog_cfg_t [cec_pkg::NCMP-1:0] cfg_i,
  input wire logic [cec_pkg::NCMP-1:0][7:0] plus_i,
  input wire logic [cec_pkg::NCMP-1:0][7:0] minus_i,
  output logic [cec_pkg::NCMP-1:0] raw_o = '0
);
  always @(posedge clk_i) begin
    for (int k = 0; k < cec_pkg::NCMP; k++) begin
      if (cfg_i[k].powered) begin
        raw_o[k] <= plus_i[k] > minus_i[k];
      end else begin
        // An unpowered core means nothing: keep it moving so no level passes by luck
        raw_o[k] <= ~raw_o[k];
      end
    end
  end
endmodule // cec_partner

// *** testbench/cec_top_tb.sv ***
`timescale 1ns/10ps
module cec_top_tb;
  // ==========================================
  // Signals
  localparam logic [7:0] A_IS = cec_pkg::ADDR_IRQ_STAT;
  localparam logic [7:0] A_IM = cec_pkg::ADDR_IRQ_MASK;
  localparam logic [7:0] A_ST = cec_pkg::ADDR_STAT;
  logic clk;
  logic nrst = 1'b0;
  logic idle = 1'b0;
  cec_pkg::cec_axi_req_t req = '0;
  cec_pkg::cec_axi_rsp_t rsp;
  cec_pkg::cec_analog_cfg_t [cec_pkg::NCMP-1:0] cfg;
  logic [cec_pkg::NCMP-1:0] raw;
  logic [cec_pkg::NCMP-1:0] pin;
  logic [cec_pkg::NCMP-1:0] pin_oe;
  logic [cec_pkg::NCMP-1:0] pulse;
  logic irq;
  logic [cec_pkg::NCMP-1:0][7:0] vp = '0;
  logic [cec_pkg::NCMP-1:0][7:0] vm = '0;
  int pc [cec_pkg::NCMP] = '{default: 0};
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] rd_data;
  logic [1:0] resp;

  cec_top u_cec_top (
    .clk_i(clk),
    .nrst_i(nrst),
    .axi_req_i(req),
    .axi_rsp_o(rsp),
    .idle_i(idle),
    .raw_result_i(raw),
    .analog_cfg_o(cfg),
    .pin_o(pin),
    .pin_oe_o(pin_oe),
    .event_pulse_o(pulse),
    .irq_o(irq)
  );

  cec_partner u_cec_partner (
    .clk_i(clk),
    .cfg_i(cfg),
    .plus_i(vp),
    .minus_i(vm),
    .raw_o(raw)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counted at the falling edge, where the pulse has settled
  always @(negedge clk) begin
    for (int k = 0; k < cec_pkg::NCMP; k++) begin
      if (pulse[k] === 1'b1) begin
        pc[k] = pc[k] + 1;
      end
    end
  end

  // ==========================================
  // Tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] ca(input int i);
    return 8'(cec_pkg::ADDR_CTRL1 + cec_pkg::ADDR_CTRL_STEP * i);
  endfunction

  function automatic bit exp_edge(input cec_pkg::cec_edge_t m, input bit o, input bit n);
    case (m)
      cec_pkg::EDGE_ANY: return o != n;
      cec_pkg::EDGE_RISE: return !o && n;
      cec_pkg::EDGE_FALL: return o && !n;
      default: return 1'b0;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta;
    bit tw;
    bit tb;
    int n;
    n = 0;
    tb = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tb = req.bready && rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) req.bready <= 1'b0;
      n++;
    end
    if (!tb) err_total++;
  endtask

  task automatic rd(input logic [7:0] a);
    bit ta;
    bit tr;
    int n;
    n = 0;
    tr = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge clk);
      ta = req.arvalid && rsp.arready;
      tr = req.rready && rsp.rvalid;
      rd_data = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) req.rready <= 1'b0;
      n++;
    end
    if (!tr) err_total++;
  endtask

  task automatic edge_trial(input int i, input int m, input bit inv);
    logic [15:0] c;
    bit oe;
    bit e1;
    bit e2;
    int n0;
    logic [7:0] lo;
    logic [7:0] hi;
    oe = 1'($urandom % 2);
    c = {1'b1, oe, inv, 5'h00, 2'(m), 1'b0, 1'($urandom % 2), 2'h0, 2'($urandom % 4)};
    lo = 8'($urandom % 100);
    hi = 8'(150 + $urandom % 100);
    @(posedge clk);
    vp[i] <= lo;
    vm[i] <= 8'h78;
    wr(ca(i), {16'h0000, c});
    cyc(4);
    wr(ca(i), {16'h0000, c});
    wr(A_IS, 32'h0000000F);
    n0 = pc[i];
    @(posedge clk);
    vp[i] <= hi;
    cyc(4);
    e1 = exp_edge(cec_pkg::cec_edge_t'(m), inv, !inv);
    chk(32'(pc[i] - n0), 32'(e1));
    n0 = pc[i];
    vp[i] <= lo;
    cyc(4);
    e2 = e1 ? 1'b0 : exp_edge(cec_pkg::cec_edge_t'(m), !inv, inv);
    chk(32'(pc[i] - n0), 32'(e2));
    rd(ca(i));
    chk(rd_data, {16'h0000, c | {6'h00, e1 | e2, inv, 8'h00}});
    rd(A_ST);
    chk({rd_data[8+i], rd_data[i]}, {e1 | e2, inv});
    wr(A_IM, 32'(1 << i));
    @(negedge clk);
    chk(irq, e1 | e2);
    chk(pin_oe[i], oe);
    chk(pin[i], oe & inv);
    chk(cfg[i], {1'b1, c[4], c[1:0]});
    wr(A_IM, 32'h00000000);
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    int n0;
    void'($urandom(90211));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      rd(8'(4 * a));
      chk(rd_data, 32'h00000000);
      chk(resp, (a == 7) ? cec_pkg::RESP_SLVERR : cec_pkg::RESP_OKAY);
    end
    wr(8'h1C, 32'h0000FFFF);
    chk(resp, cec_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 2; v++) begin
        edge_trial(int'($urandom % 4), m, v[0]);
      end
    end
    $display("test edges done");
    for (int i = 0; i < 4; i++) begin
      wr(ca(i), 32'h000000C0);
      n0 = pc[i];
      vp[i] <= ~vp[i];
      cyc(6);
      chk(32'(pc[i] - n0), 32'h0);
      rd(ca(i));
      chk(rd_data, 32'h000000C0);
      chk(pin_oe[i], 1'b0);
    end
    $display("test disabled done");
    // Channel 0 may never have been picked by the random trials, so set its threshold here
    vm[0] <= 8'h78;
    vp[0] <= 8'h10;
    wr(ca(0), 32'h000080C0);
    cyc(4);
    wr(ca(0), 32'h000080C0);
    wr(A_ST, 32'h00008000);
    idle <= 1'b1;
    cyc(2);
    n0 = pc[0];
    vp[0] <= 8'hF0;
    cyc(6);
    chk(32'(pc[0] - n0), 32'h0);
    chk(cfg[0].powered, 1'b0);
    rd(ca(0));
    chk(rd_data[8], 1'b0);
    idle <= 1'b0;
    cyc(6);
    wr(ca(0), 32'h000080C0);
    n0 = pc[0];
    vp[0] <= 8'h10;
    cyc(6);
    chk(32'(pc[0] - n0), 32'h1);
    wr(A_ST, 32'h00000000);
    wr(ca(0), 32'h000080C0);
    idle <= 1'b1;
    n0 = pc[0];
    vp[0] <= 8'hF0;
    cyc(6);
    chk(32'(pc[0] - n0), 32'h1);
    idle <= 1'b0;
    $display("test idle done");
    finish_test();
  end
endmodule // cec_top_tb
